/* rtl/interrupt_trigger_mode_select.sv */
`include "irq_mode_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module interrupt_trigger_mode_select
  import irq_mode_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // register port of the serial host interface, one cycle strobes
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // raw source conditions: transfer, slip, estimator done, input faster
  input wire logic [3:0] src_cond_in,
  // flags: bit0 xfer_done, bit1 source_slip, bit2 estimator, bit3 ratio
  output logic [3:0] irq_flags_out,
  output logic irq_n_out
);

  // elaboration checks: the map is byte wide and offset 0x0c needs at
  // least four address bits to stay apart from the other offsets
  localparam int NUM_SRC = `NUM_SOURCES;

  if (DATA_W != 8) begin : g_bad_data_w
    $error("interrupt_trigger_mode_select: DATA_W must be 8");
  end
  if (ADDR_W < 4) begin : g_bad_addr_w
    $error("interrupt_trigger_mode_select: ADDR_W below 4");
  end
  if (NUM_SRC != 4) begin : g_bad_src_count
    $error("interrupt_trigger_mode_select: four sources expected");
  end

  // source indices, shared by the flag, condition and mask layouts
  localparam int SRC_XFER = 0;
  localparam int SRC_SLIP = 1;
  localparam int SRC_ESTIMATOR = 2;
  localparam int SRC_RATIO = 3;

  // all state of the block, registered as one word
  typedef struct packed {
    logic [7:0] mode;
    logic [3:0] mask;
    logic [3:0] cond_q;
    logic [3:0] flags;
    logic [7:0] rdata;
    logic rvalid;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // reset image: rising-edge mode everywhere, all sources masked
  localparam state_t ST_RESET = '{
    mode: `TRIGGER_MODE_RESET,
    mask: 4'(`IRQ_MASK_RESET),
    cond_q: 4'h0,
    flags: 4'h0,
    rdata: 8'h00,
    rvalid: 1'b0
  };

  // mask register bit for source i
  function automatic int mask_pos(input int i);
    case (i)
      0: mask_pos = `XFER_DONE_MASK_BIT;
      1: mask_pos = `SOURCE_SLIP_MASK_BIT;
      2: mask_pos = `ESTIMATOR_DONE_MASK_BIT;
      default: mask_pos = `INPUT_FASTER_MASK_BIT;
    endcase
  endfunction

  // mode field position for source i
  function automatic int sel_pos(input int i);
    case (i)
      0: sel_pos = `XFER_DONE_SEL_LSB;
      1: sel_pos = `SOURCE_SLIP_SEL_LSB;
      2: sel_pos = `ESTIMATOR_DONE_SEL_LSB;
      default: sel_pos = `RATE_COMPARE_SEL_LSB;
    endcase
  endfunction

  // true when the bus address names the given register offset
  function automatic logic addr_is(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0] offs);
    addr_is = (addr == ADDR_W'(offs));
  endfunction

  // one source's qualification: edge against last cycle's level, or
  // the level itself; reserved code 11 qualifies nothing, so a stray
  // write of it silences the source rather than raising noise
  function automatic logic qualify(input trig_mode_t mode,
                                   input logic cur,
                                   input logic prev);
    case (mode)
      TRIG_RISE: qualify = cur & ~prev;
      TRIG_FALL: qualify = ~cur & prev;
      TRIG_LEVEL: qualify = cur;
      default: qualify = 1'b0;
    endcase
  endfunction

  logic sel_mode;
  logic sel_mask;
  logic sel_status;
  logic rd_hit_flags;
  logic [NUM_SRC-1:0] hit;
  logic [7:0] mask_view;
  logic [7:0] rd_word;

  // named views of the mask and flag bits, one per source
  logic xfer_done_mask;
  logic source_slip_mask;
  logic estimator_done_mask;
  logic input_faster_mask;
  logic xfer_done_flag;
  logic source_slip_flag;
  logic estimator_done_flag;
  logic input_faster_flag;

  assign xfer_done_mask = st_r.mask[SRC_XFER];
  assign source_slip_mask = st_r.mask[SRC_SLIP];
  assign estimator_done_mask = st_r.mask[SRC_ESTIMATOR];
  assign input_faster_mask = st_r.mask[SRC_RATIO];
  assign xfer_done_flag = st_r.flags[SRC_XFER];
  assign source_slip_flag = st_r.flags[SRC_SLIP];
  assign estimator_done_flag = st_r.flags[SRC_ESTIMATOR];
  assign input_faster_flag = st_r.flags[SRC_RATIO];

  // register selects, decoded once for both the write and read paths
  assign sel_mode = addr_is(reg_addr_in, `TRIGGER_MODE_OFFS);
  assign sel_mask = addr_is(reg_addr_in, `IRQ_MASK_OFFS);
  assign sel_status = addr_is(reg_addr_in, `STATUS_SUMMARY_OFFS);
  // reading status is the clear strobe for every flag
  assign rd_hit_flags = reg_rd_in & sel_status;

  // per-source qualification against the field that source owns; the
  // history bit is 0 after reset, so a condition already high at
  // release counts as a rising edge
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    trig_mode_t field_mode;
    assign field_mode = trig_mode_t'(st_r.mode[sel_pos(i) +: 2]);
    assign hit[i] = qualify(field_mode, src_cond_in[i], st_r.cond_q[i]);
  end

  // mask register view: four mask bits exist, the rest read as 0
  always_comb begin
    mask_view = 8'h00;
    mask_view[`XFER_DONE_MASK_BIT] = xfer_done_mask;
    mask_view[`SOURCE_SLIP_MASK_BIT] = source_slip_mask;
    mask_view[`ESTIMATOR_DONE_MASK_BIT] = estimator_done_mask;
    mask_view[`INPUT_FASTER_MASK_BIT] = input_faster_mask;
  end

  // readback word for the addressed register; unmapped offsets give 0
  // and the summary bit shows the flags before this cycle's clear
  always_comb begin
    rd_word = 8'h00;
    if (sel_mode) begin
      rd_word = st_r.mode;
    end else if (sel_mask) begin
      rd_word = mask_view;
    end else if (sel_status) begin
      rd_word[`CONVERTER_SUMMARY_BIT] = |st_r.flags;
    end
  end

  // next state: register writes, flag capture, read-clear of status
  always_comb begin
    st_nxt = st_r;
    // history is kept even while masked, so unmasking never turns a
    // level that has stood for a while into a fresh edge
    st_nxt.cond_q = src_cond_in;
    st_nxt.rvalid = reg_rd_in;
    if (reg_wr_in) begin
      if (sel_mode) begin
        st_nxt.mode = reg_wdata_in[7:0];
      end else if (sel_mask) begin
        for (int i = 0; i < NUM_SRC; i++) begin
          st_nxt.mask[i] = reg_wdata_in[mask_pos(i)];
        end
      end
    end
    // reading status clears flags; a new hit in the same cycle wins
    if (rd_hit_flags) begin
      st_nxt.flags = 4'h0;
    end
    // only unmasked sources may set a flag; the old mask is used, so a
    // mask write takes hold one cycle later
    st_nxt.flags = st_nxt.flags | (hit & st_r.mask);
    // read data stands one cycle and is 0 whenever no read was taken
    st_nxt.rdata = 8'h00;
    if (reg_rd_in) begin
      st_nxt.rdata = rd_word;
    end
  end

  // single state register
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // read port and flags come straight from the state register
  assign reg_rdata_out = st_r.rdata;
  assign reg_rvalid_out = st_r.rvalid;
  assign irq_flags_out = {input_faster_flag, estimator_done_flag,
    source_slip_flag, xfer_done_flag};
  // active-low summary line, low while any flag stands
  assign irq_n_out = ~(|st_r.flags);

endmodule
`default_nettype wire

/* common/irq_mode_consts.svh */
`ifndef IRQ_MODE_CONSTS_SVH
`define IRQ_MODE_CONSTS_SVH
// register offsets on the host register port
`define STATUS_SUMMARY_OFFS 8'h02
`define IRQ_MASK_OFFS 8'h0b
`define TRIGGER_MODE_OFFS 8'h0c
// mode register field positions (low bit of each 2-bit field)
`define XFER_DONE_SEL_LSB 0
`define SOURCE_SLIP_SEL_LSB 2
`define ESTIMATOR_DONE_SEL_LSB 4
`define RATE_COMPARE_SEL_LSB 6
// mask register bit positions
`define XFER_DONE_MASK_BIT 0
`define SOURCE_SLIP_MASK_BIT 1
`define ESTIMATOR_DONE_MASK_BIT 4
`define INPUT_FASTER_MASK_BIT 5
// summary bit position in the status register
`define CONVERTER_SUMMARY_BIT 0
// reset values
`define TRIGGER_MODE_RESET 8'h00
`define IRQ_MASK_RESET 8'h00
`define NUM_SOURCES 4
`endif

/* common/irq_mode_pkg.sv */
package irq_mode_pkg;
  // trigger qualification codes
  typedef enum logic [1:0] {
    TRIG_RISE = 2'h0,
    TRIG_FALL = 2'h1,
    TRIG_LEVEL = 2'h2,
    TRIG_RSVD = 2'h3
  } trig_mode_t;
endpackage

/* dv/irq_mode_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_mode_chk (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic [3:0] src_cond_in,
  input wire logic [3:0] irq_flags_out,
  input wire logic irq_n_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic [7:0] a = reg_addr_in;
  AST_IRQ: assert property (irq_n_out == !(|irq_flags_out))
    else $error("irq level");
  AST_RV: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("no rvalid");
  AST_RD0: assert property (!reg_rvalid_out |-> reg_rdata_out == 0)
    else $error("idle rdata");
  AST_UNMAP: assert property (reg_rd_in && a > 8'h0c |=> !reg_rdata_out)
    else $error("unmapped rdata");
  AST_MODE: assert property ((reg_wr_in && a == 8'h0c) ##1
    (reg_rd_in && a == 8'h0c && !reg_wr_in) |=>
    reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("mode readback");
  AST_MASK: assert property ((reg_wr_in && a == 8'h0b) ##1
    (reg_rd_in && a == 8'h0b && !reg_wr_in) |=>
    reg_rdata_out == ($past(reg_wdata_in, 2) & 8'h33))
    else $error("mask readback");
  AST_SUM: assert property (reg_rd_in && a == 8'h02 |=>
    reg_rdata_out[0] == |$past(irq_flags_out))
    else $error("summary bit");
  AST_HOLD: assert property (irq_flags_out[3] &&
    !(reg_rd_in && a == 8'h02) |=> irq_flags_out[3])
    else $error("flag dropped");
  // a new flag needs its condition high one or two cycles before the flag appears
  AST_CAUSE: assert property (!(|(irq_flags_out &
    ~$past(irq_flags_out) &
    ~($past(src_cond_in) | $past(src_cond_in, 2)))))
    else $error("flag set without cause");
endmodule
bind interrupt_trigger_mode_select irq_mode_chk chk_i (
  .ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out),
  .src_cond_in(src_cond_in),
  .irq_flags_out(irq_flags_out),
  .irq_n_out(irq_n_out)
);
`default_nettype wire

/* dv/test_interrupt_trigger_mode_select.sv */
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_trigger_mode_select;
  logic ref_clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic reg_rvalid_out, irq_n_out, rv;
  logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, rx;
  logic [7:0] md = 0, mk = 0, w;
  logic [3:0] src_cond_in = 0, irq_flags_out, h, fl = 0, pv = 0;
  logic [7:0] at[4] = '{8'h02, 8'h0b, 8'h0c, 8'h5a};
  int bad_count, cmp_count, cyc;
  always #2 ref_clk_in = ~ref_clk_in;
  interrupt_trigger_mode_select interrupt_trigger_mode_select_i (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out),
    .src_cond_in(src_cond_in),
    .irq_flags_out(irq_flags_out),
    .irq_n_out(irq_n_out)
  );
  // hang guard, well above the 3005 cycles of the run
  always @(posedge ref_clk_in) if (++cyc > 4000) begin
    bad_count++;
    final_report;
  end
  task chk(string n, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (e !== s) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // model steps on the inputs the design saw, then compares outputs
  initial begin
    void'($urandom(32'hf5f9));
    repeat (5) @(posedge ref_clk_in);
    sys_rst_in <= 0;
    repeat (3000) begin
      @(posedge ref_clk_in);
      for (int i = 0; i < 4; i++)
        case (md[2*i+:2])
          0: h[i] = src_cond_in[i] & !pv[i];
          1: h[i] = !src_cond_in[i] & pv[i];
          2: h[i] = src_cond_in[i];
          default: h[i] = 0; // reserved code qualifies nothing
        endcase
      h = h & {mk[5], mk[4], mk[1], mk[0]};
      rv = reg_rd_in;
      rx = !rv ? 0 : reg_addr_in == 8'h02 ? {7'h0, |fl} :
        reg_addr_in == 8'h0b ? mk : reg_addr_in == 8'h0c ? md : 8'h0;
      if (rv && reg_addr_in == 8'h02) fl = 0;
      fl = fl | h; // a hit beats the clear
      if (reg_wr_in && reg_addr_in == 8'h0c) md = reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 8'h0b) mk = reg_wdata_in & 8'h33;
      pv = src_cond_in;
      {reg_wr_in, reg_rd_in, src_cond_in} <= 6'($urandom);
      reg_addr_in <= at[$urandom % 4];
      w = 8'($urandom);
      // software never writes code 11 into the ratio field
      if (w[7:6] == 2'h3) w[7] = 1'b0;
      reg_wdata_in <= w;
      #1;
      chk("flags", {4'h0, fl}, {4'h0, irq_flags_out});
      chk("irq_n", {7'h0, ~|fl}, {7'h0, irq_n_out});
      chk("rvalid", {7'h0, rv}, {7'h0, reg_rvalid_out});
      chk("rdata", rx, reg_rdata_out);
    end
    final_report;
  end
endmodule
`default_nettype wire
